// file: common/osc_clock_pkg.sv
// package: oscillator clock control constants, types and register layout
//
// Overview of operation
// - 10-bit counter waits 1024 crystal periods
// - start-up wait on POR, BOR, sleep wake
// - 32k secondary oscillator runs while enabled
// - secondary clocks device: group 00, enabled
// - PLL multiplies primary by four, eight, sixteen
// - lock bit follows PLL lock, read only
// - group 001 selects fast internal RC
// - four-bit trim, 1.5% steps, signed code
// - group 111 plus fuses 00101-00111 multiply RC
// - slow RC on at reset, kept if needed
// - monitor enabled keeps slow RC except sleep
// - failure: trap, group to RC, flag, switch clear
// - watchdog keeps slow RC clock when monitor off
// - power-up expiry before start forces failure
// - five groups; primary choice from fuses
// - current group read only; both fuse loaded
// - switch bit starts switch; clearing aborts
// - monitor fuses 1x disable switching and monitor
// - switching off: fuses choose, group only reflects
package osc_clock_pkg;

   // register byte addresses
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;

   // control register field positions
   localparam int POS_SWITCH_ENABLE = 0;
   localparam int POS_SECONDARY_EN = 1;
   localparam int POS_CLOCK_FAIL = 3;
   localparam int POS_LOCK = 5;
   localparam int POS_NEW_GROUP = 8;
   localparam int POS_TRIM_LO = 10;
   localparam int POS_CUR_GROUP = 12;
   localparam int POS_TRIM_HI = 14;

   // groups
   localparam logic [2:0] GROUP_SECONDARY = 3'h0;
   localparam logic [2:0] GROUP_FAST_RC = 3'h1;
   localparam logic [2:0] GROUP_SLOW_RC = 3'h2;
   localparam logic [2:0] GROUP_PRIMARY = 3'h3;
   localparam logic [2:0] GROUP_PRIMARY_PLL = 3'h7;

   // primary selection fuse codes that use the fast RC with the PLL
   localparam logic [4:0] FPS_RC_X4 = 5'h05;
   localparam logic [4:0] FPS_RC_X8 = 5'h06;
   localparam logic [4:0] FPS_RC_X16 = 5'h07;

   // unlock keys
   localparam logic [7:0] KEY_FIRST = 8'h46;
   localparam logic [7:0] KEY_SECOND = 8'h57;

   // timing
   localparam int STARTUP_COUNT = 1024;
   localparam int FAIL_WINDOW = 16;
   localparam logic [1:0] PLL_MUL_X4 = 2'h1;
   localparam logic [1:0] PLL_MUL_X8 = 2'h2;
   localparam logic [1:0] PLL_MUL_X16 = 2'h3;

   typedef enum logic [3:0] {
      SW_IDLE = 4'b0001,
      SW_START = 4'b0010,
      SW_WAIT = 4'b0100,
      SW_DONE = 4'b1000
   } switch_state_e;

   typedef struct packed {
      logic [1:0] key_stage;
      logic [2:0] cur_group;
      logic [2:0] new_group;
      logic [3:0] trim;
      logic secondary_en;
      logic switch_enable;
      logic clock_fail;
      logic fail_trap;
      logic [9:0] startup_cnt;
      logic startup_done;
      logic [4:0] fail_cnt;
      logic slow_rc_on;
      logic [15:0] rdata;
      logic rvalid;
      logic pulse_wait;
      switch_state_e sw_state;
   } osc_state_s;

endpackage

// file: hdl/osc_clock_ctrl.sv
// oscillator clock control with switching and fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
module osc_clock_ctrl
   import osc_clock_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_COUNT,
   parameter int FAIL_CYCLES = FAIL_WINDOW
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // avalon slave
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // fuses and system status
   input wire logic [2:0] i_group_select_fuses,
   input wire logic [4:0] i_primary_select_fuses,
   input wire logic [2:0] i_switch_monitor_fuses,
   input wire logic i_por_or_bor,
   input wire logic i_sleep,
   input wire logic i_sleep_wake,
   input wire logic i_powerup_timer_done,
   input wire logic i_watchdog_enable,
   input wire logic i_software_watchdog_enable,
   // analog feedback, asynchronous
   input wire logic i_pll_lock,
   input wire logic i_osc_tick,
   input wire logic i_sys_clock_tick,
   // clock controls
   output logic [2:0] o_active_group,
   output logic [1:0] o_pll_multiplier,
   output logic [3:0] o_frc_trim,
   output logic o_secondary_osc_on,
   output logic o_slow_rc_on,
   output logic o_clock_released,
   output logic o_clock_fail_trap
);

   // counters are 10 and 5 bits wide
   if (STARTUP_CYCLES < 2 || STARTUP_CYCLES > 1024) begin
      $error("STARTUP_CYCLES out of range");
   end
   if (FAIL_CYCLES < 2 || FAIL_CYCLES > 31) begin
      $error("FAIL_CYCLES out of range");
   end

   localparam logic [9:0] STARTUP_LAST = 10'(STARTUP_CYCLES - 1);
   localparam logic [4:0] FAIL_LAST = 5'(FAIL_CYCLES - 1);

   // three-stage synchronisers; stage 2 and 3 agreement accepts change
   logic [2:0] lock_sync_r, osc_sync_r, sys_sync_r;
   logic lock_q_r, osc_q_r, sys_q_r, osc_prev_r, sys_prev_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         lock_sync_r <= 3'h0;
         osc_sync_r <= 3'h0;
         sys_sync_r <= 3'h0;
         lock_q_r <= 1'b0;
         osc_q_r <= 1'b0;
         sys_q_r <= 1'b0;
         osc_prev_r <= 1'b0;
         sys_prev_r <= 1'b0;
      end else begin
         lock_sync_r <= {lock_sync_r[1:0], i_pll_lock};
         osc_sync_r <= {osc_sync_r[1:0], i_osc_tick};
         sys_sync_r <= {sys_sync_r[1:0], i_sys_clock_tick};
         if (lock_sync_r[1] == lock_sync_r[2]) begin
            lock_q_r <= lock_sync_r[2];
         end
         if (osc_sync_r[1] == osc_sync_r[2]) begin
            osc_q_r <= osc_sync_r[2];
         end
         if (sys_sync_r[1] == sys_sync_r[2]) begin
            sys_q_r <= sys_sync_r[2];
         end
         osc_prev_r <= osc_q_r;
         sys_prev_r <= sys_q_r;
      end
   end

   wire logic osc_edge = osc_q_r & ~osc_prev_r;
   wire logic sys_edge = sys_q_r & ~sys_prev_r;

   function automatic logic is_crystal(input logic [2:0] grp,
                                       input logic [4:0] fps);
      is_crystal = (grp == GROUP_SECONDARY) ||
         ((grp == GROUP_PRIMARY || grp == GROUP_PRIMARY_PLL) &&
          (fps[4:2] == 3'h0 || fps[4:2] == 3'h1 || fps[4:3] == 2'h2) &&
          // fast RC behind the PLL needs no crystal wait
          fps != FPS_RC_X4 && fps != FPS_RC_X8 && fps != FPS_RC_X16);
   endfunction

   osc_state_s st_r, st_nxt;
   logic switching_on, monitor_on, sel_we, key_ok;
   logic [2:0] eff_group;

   always_comb begin
      // 1x disables both switching and monitor
      switching_on = ~i_switch_monitor_fuses[1];
      monitor_on = ~i_switch_monitor_fuses[1] & ~i_switch_monitor_fuses[0];
      eff_group = switching_on ? st_r.cur_group
                               : i_group_select_fuses;
      sel_we = i_write && !st_r.pulse_wait && i_address == ADDR_CONTROL;
      key_ok = st_r.key_stage == 2'h2;
      st_nxt = st_r;
      st_nxt.fail_trap = 1'b0;
      st_nxt.rvalid = 1'b0;
      st_nxt.pulse_wait = (i_read || i_write) && !st_r.pulse_wait;

      // register access; low byte needs the key sequence
      if (sel_we && i_byteenable[0]) begin
         if (key_ok) begin
            st_nxt.key_stage = 2'h0;
            st_nxt.secondary_en = i_writedata[POS_SECONDARY_EN];
            if (!i_writedata[POS_SWITCH_ENABLE]) begin
               st_nxt.switch_enable = 1'b0;
            end else if (switching_on) begin
               st_nxt.switch_enable = 1'b1;
            end
            // clock fail flag is cleared only by a zero write
            if (!i_writedata[POS_CLOCK_FAIL]) begin
               st_nxt.clock_fail = 1'b0;
            end
         end else if (i_writedata[7:0] == KEY_FIRST) begin
            st_nxt.key_stage = 2'h1;
         end else if (st_r.key_stage == 2'h1 &&
                      i_writedata[7:0] == KEY_SECOND) begin
            st_nxt.key_stage = 2'h2;
         end else begin
            st_nxt.key_stage = 2'h0;
         end
      end else if (i_write && !st_r.pulse_wait) begin
         st_nxt.key_stage = 2'h0;
      end
      if (sel_we && i_byteenable[1]) begin
         st_nxt.new_group = i_writedata[POS_NEW_GROUP +: 3];
         st_nxt.trim = {i_writedata[POS_TRIM_HI +: 2],
                        i_writedata[POS_TRIM_LO +: 2]};
      end
      if (i_read && !st_r.pulse_wait) begin
         st_nxt.rvalid = 1'b1;
         if (i_address == ADDR_CONTROL) begin
            st_nxt.rdata = '0;
            st_nxt.rdata[POS_TRIM_HI +: 2] = st_r.trim[3:2];
            st_nxt.rdata[POS_CUR_GROUP +: 2] = eff_group[1:0];
            st_nxt.rdata[POS_TRIM_LO +: 2] = st_r.trim[1:0];
            st_nxt.rdata[POS_NEW_GROUP +: 2] = st_r.new_group[1:0];
            st_nxt.rdata[POS_LOCK] = lock_q_r;
            st_nxt.rdata[POS_CLOCK_FAIL] = st_r.clock_fail;
            st_nxt.rdata[POS_SECONDARY_EN] = st_r.secondary_en;
            st_nxt.rdata[POS_SWITCH_ENABLE] = st_r.switch_enable;
         end else if (i_address == ADDR_STATUS) begin
            st_nxt.rdata = {11'h0, st_r.startup_done, eff_group,
                            st_r.sw_state == SW_IDLE};
            st_nxt.rdata[15] = st_r.cur_group[2];
         end else begin
            st_nxt.rdata = 16'h0;
         end
      end

      // group switch sequence between whole groups only
      case (st_r.sw_state)
         SW_IDLE: begin
            if (st_r.switch_enable && switching_on) begin
               st_nxt.sw_state = SW_START;
            end
         end
         SW_START: begin
            st_nxt.startup_cnt = 10'h0;
            st_nxt.startup_done =
               !is_crystal(st_r.new_group, i_primary_select_fuses);
            st_nxt.sw_state = SW_WAIT;
         end
         SW_WAIT: begin
            if (!st_r.switch_enable) begin
               st_nxt.sw_state = SW_IDLE;
            end else if (st_r.startup_done) begin
               st_nxt.sw_state = SW_DONE;
            end
         end
         SW_DONE: begin
            st_nxt.cur_group = st_r.new_group;
            st_nxt.switch_enable = 1'b0;
            st_nxt.sw_state = SW_IDLE;
         end
         default: st_nxt.sw_state = SW_IDLE;
      endcase

      // crystal start-up wait, restarted on reset and sleep wake
      if (i_por_or_bor || i_sleep_wake) begin
         st_nxt.startup_cnt = 10'h0;
         st_nxt.startup_done = !is_crystal(eff_group, i_primary_select_fuses);
      end else if (!st_r.startup_done && osc_edge &&
                   st_r.sw_state != SW_START) begin
         st_nxt.startup_cnt = st_r.startup_cnt + 10'h1;
         if (st_r.startup_cnt == STARTUP_LAST) begin
            st_nxt.startup_done = 1'b1;
         end
      end
      if (i_por_or_bor) begin
         st_nxt.cur_group = i_group_select_fuses;
         st_nxt.new_group = i_group_select_fuses;
      end

      // fail-safe monitor; no system clock edge in window is failure
      // a reload must not race a trap on the group field
      if (!monitor_on || i_sleep || !i_powerup_timer_done || sys_edge ||
          i_por_or_bor) begin
         st_nxt.fail_cnt = 5'h0;
      end else if (st_r.fail_cnt != FAIL_LAST) begin
         st_nxt.fail_cnt = st_r.fail_cnt + 5'h1;
      end else if (st_r.cur_group != GROUP_FAST_RC) begin
         // also catches a slow crystal still starting at expiry
         st_nxt.fail_cnt = 5'h0;
         st_nxt.fail_trap = 1'b1;
         st_nxt.cur_group = GROUP_FAST_RC;
         st_nxt.clock_fail = 1'b1;
         st_nxt.switch_enable = 1'b0;
         st_nxt.sw_state = SW_IDLE;
      end

      // slow RC keep-alive; watchdog keeps it while the monitor is off
      if (i_por_or_bor) begin
         st_nxt.slow_rc_on = 1'b1;
      end else if (monitor_on) begin
         st_nxt.slow_rc_on = !i_sleep;
      end else if (i_powerup_timer_done) begin
         st_nxt.slow_rc_on = i_watchdog_enable ||
            i_software_watchdog_enable ||
            eff_group == GROUP_SLOW_RC;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= '{key_stage: 2'h0, cur_group: GROUP_FAST_RC,
                   new_group: GROUP_FAST_RC, trim: 4'h0,
                   secondary_en: 1'b0, switch_enable: 1'b0,
                   clock_fail: 1'b0, fail_trap: 1'b0,
                   startup_cnt: 10'h0, startup_done: 1'b0,
                   fail_cnt: 5'h0, slow_rc_on: 1'b1,
                   rdata: 16'h0, rvalid: 1'b0, pulse_wait: 1'b0,
                   sw_state: SW_IDLE};
      end else begin
         st_r <= st_nxt;
      end
   end

   // registered outputs
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_readdata <= 32'h0;
         o_waitrequest <= 1'b1;
         o_active_group <= GROUP_FAST_RC;
         o_pll_multiplier <= 2'h0;
         o_frc_trim <= 4'h0;
         o_secondary_osc_on <= 1'b0;
         o_slow_rc_on <= 1'b1;
         o_clock_released <= 1'b0;
         o_clock_fail_trap <= 1'b0;
      end else begin
         o_readdata <= {16'h0, st_nxt.rdata};
         o_waitrequest <= !st_nxt.pulse_wait;
         o_active_group <= (eff_group == GROUP_SECONDARY &&
                            !st_r.secondary_en) ? GROUP_FAST_RC
                                                : eff_group;
         if (eff_group == GROUP_PRIMARY_PLL) begin
            o_pll_multiplier <= i_primary_select_fuses[1:0];
         end else begin
            o_pll_multiplier <= 2'h0;
         end
         o_frc_trim <= st_r.trim;
         o_secondary_osc_on <= st_r.secondary_en;
         o_slow_rc_on <= st_r.slow_rc_on;
         o_clock_released <= st_r.startup_done &&
            (eff_group != GROUP_PRIMARY_PLL || lock_q_r);
         o_clock_fail_trap <= st_r.fail_trap;
      end
   end

   // checks
   chk_failure_side_effects: assert property (@(posedge i_clock)
      disable iff (!i_rstn) st_r.fail_trap |-> st_r.clock_fail &&
      st_r.cur_group == GROUP_FAST_RC && !st_r.switch_enable
      ##1 o_clock_fail_trap) else $error("failure effects wrong");
   chk_startup_count: assert property (@(posedge i_clock)
      disable iff (!i_rstn) $rose(st_r.startup_done) && !i_por_or_bor &&
      !$past(i_sleep_wake) && !$past(i_por_or_bor) &&
      $past(st_r.sw_state) != SW_START
      |-> $past(st_r.startup_cnt) == STARTUP_LAST)
      else $error("start-up count wrong");
   chk_disabled_no_switch: assert property (@(posedge i_clock)
      disable iff (!i_rstn) i_switch_monitor_fuses[1] |=> !st_r.fail_trap
      && !$rose(st_r.switch_enable) && st_r.sw_state != SW_DONE)
      else $error("switch when disabled");
   chk_abort_switch: assert property (@(posedge i_clock)
      disable iff (!i_rstn) st_r.sw_state == SW_WAIT && !st_r.switch_enable
      |=> st_r.sw_state == SW_IDLE) else $error("abort ignored");
   chk_fuse_load: assert property (@(posedge i_clock)
      disable iff (!i_rstn) i_por_or_bor |=> st_r.cur_group ==
      $past(i_group_select_fuses)) else $error("fuse load wrong");
   chk_slow_rc_monitor: assert property (@(posedge i_clock)
      disable iff (!i_rstn) monitor_on && !i_sleep && !i_por_or_bor
      |=> ##1 o_slow_rc_on | $past(i_sleep) | $past(i_sleep, 2))
      else $error("slow rc off");
   chk_fail_window: assert property (@(posedge i_clock)
      disable iff (!i_rstn) st_r.fail_trap |-> $past(st_r.fail_cnt) ==
      FAIL_LAST) else $error("window wrong");
   chk_lock_bit: assert property (@(posedge i_clock)
      disable iff (!i_rstn) i_read && !st_r.pulse_wait &&
      i_address == ADDR_CONTROL |=> o_readdata[POS_LOCK] == $past(lock_q_r))
      else $error("lock bit wrong");

endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the oscillator clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top import osc_clock_pkg::*; ;
   localparam int STARTUP = 8;
   localparam int LIM = 400;
   localparam logic [2:0] OFF = 3'h2;
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   logic [3:0] i_address = 4'h0;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [3:0] i_byteenable = 4'h0;
   logic [2:0] i_group_select_fuses = 3'h1;
   logic [4:0] i_primary_select_fuses = 5'h04;
   logic [2:0] i_switch_monitor_fuses = OFF;
   logic i_por_or_bor = 1'b0;
   logic i_sleep = 1'b0;
   logic i_sleep_wake = 1'b0;
   logic i_powerup_timer_done = 1'b0;
   logic i_watchdog_enable = 1'b0;
   logic i_software_watchdog_enable = 1'b0;
   logic i_pll_lock = 1'b0;
   logic i_osc_tick = 1'b0;
   logic i_sys_clock_tick = 1'b0;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic [2:0] o_active_group;
   logic [1:0] o_pll_multiplier;
   logic [3:0] o_frc_trim;
   logic o_secondary_osc_on;
   logic o_slow_rc_on;
   logic o_clock_released;
   logic o_clock_fail_trap;
   logic sys_run = 1'b1;
   logic osc_run = 1'b0;
   logic tick_ph = 1'b0;
   int osc_edges = 0;
   int trap_cnt = 0;
   int trap_base = 0;
   int miscompares = 0;
   int check_count = 0;
   int seed;
   logic [2:0] grp_want;
   logic [31:0] rdat;
   logic [2:0] grps [4] = '{GROUP_FAST_RC, GROUP_SLOW_RC, GROUP_PRIMARY,
                            GROUP_PRIMARY_PLL};

   osc_clock_ctrl #(.STARTUP_CYCLES(STARTUP), .FAIL_CYCLES(6)) dut_u (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(i_byteenable), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest),
      .i_group_select_fuses(i_group_select_fuses),
      .i_primary_select_fuses(i_primary_select_fuses),
      .i_switch_monitor_fuses(i_switch_monitor_fuses),
      .i_por_or_bor(i_por_or_bor), .i_sleep(i_sleep),
      .i_sleep_wake(i_sleep_wake),
      .i_powerup_timer_done(i_powerup_timer_done),
      .i_watchdog_enable(i_watchdog_enable),
      .i_software_watchdog_enable(i_software_watchdog_enable),
      .i_pll_lock(i_pll_lock), .i_osc_tick(i_osc_tick),
      .i_sys_clock_tick(i_sys_clock_tick), .o_active_group(o_active_group),
      .o_pll_multiplier(o_pll_multiplier), .o_frc_trim(o_frc_trim),
      .o_secondary_osc_on(o_secondary_osc_on), .o_slow_rc_on(o_slow_rc_on),
      .o_clock_released(o_clock_released),
      .o_clock_fail_trap(o_clock_fail_trap));

   initial forever #20 i_clock = ~i_clock;

   // far-side clocks seen as ticks; trap pulse lasts one cycle, so count it
   always @(posedge i_clock) begin
      // each level must last two edges to pass the agreement filter
      tick_ph <= ~tick_ph;
      if (sys_run && tick_ph) i_sys_clock_tick <= ~i_sys_clock_tick;
      if (osc_run && tick_ph) begin
         i_osc_tick <= ~i_osc_tick;
         if (!i_osc_tick) osc_edges <= osc_edges + 1;
      end
      if (o_clock_fail_trap === 1'b1) trap_cnt <= trap_cnt + 1;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic bound(input logic ok);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t wait ran out", $time);
         report_and_stop();
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [15:0] d, input logic [3:0] be);
      int n;
      n = 0;
      i_address <= a;
      i_writedata <= {16'h0000, d};
      i_byteenable <= be;
      i_write <= wr;
      i_read <= !wr;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_waitrequest !== 1'b0 && n < LIM);
      bound(o_waitrequest === 1'b0);
      rdat = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      @(posedge i_clock);
   endtask

   // guarded low byte: two key writes first
   task automatic lowb(input logic [7:0] d);
      bus(1'b1, ADDR_CONTROL, {8'h00, KEY_FIRST}, 4'h1);
      bus(1'b1, ADDR_CONTROL, {8'h00, KEY_SECOND}, 4'h1);
      bus(1'b1, ADDR_CONTROL, {8'h00, d}, 4'h1);
   endtask

   task automatic por(input logic [2:0] g, input logic [4:0] p,
                      input logic [2:0] sm);
      i_group_select_fuses <= g;
      i_primary_select_fuses <= p;
      i_switch_monitor_fuses <= sm;
      i_powerup_timer_done <= 1'b0;
      i_por_or_bor <= 1'b1;
      @(posedge i_clock);
      i_por_or_bor <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask

   function automatic logic cond(input int w);
      case (w)
         0: return o_clock_released === 1'b1;
         1: return trap_cnt != trap_base;
         2: return o_active_group === grp_want;
         default: return o_slow_rc_on === 1'b0;
      endcase
   endfunction

   task automatic wait_for(input int w);
      int n;
      n = 0;
      while (!cond(w) && n < LIM) begin
         @(posedge i_clock);
         n++;
      end
      bound(cond(w));
   endtask

   initial begin
      repeat (100000) @(posedge i_clock);
      miscompares++;
      report_and_stop();
   end

   initial begin
      logic [3:0] t;
      seed = 32'hCF3C7A5C;
      repeat (20) @(posedge i_clock);
      chk(o_waitrequest, 1'b1, "wait in reset");
      chk(o_slow_rc_on, 1'b1, "slow rc in reset");
      i_rstn <= 1'b1;
      @(posedge i_clock);
      foreach (grps[k]) begin
         por(grps[k], 5'h04, OFF);
         chk(o_active_group, grps[k], "group from fuses");
         chk(o_slow_rc_on, 1'b1, "slow rc at power-on");
         bus(1'b0, ADDR_CONTROL, 16'h0, 4'h3);
         chk(rdat[13:12], grps[k][1:0], "cur group");
         chk(rdat[9:8], grps[k][1:0], "new group");
         bus(1'b0, ADDR_STATUS, 16'h0, 4'h3);
         chk(rdat[15], grps[k][2], "cur group top");
      end
      $display("test fuse groups done");
      // trim -7.5% keeps the fast RC under the x16 ceiling
      bus(1'b1, ADDR_CONTROL, 16'h8C00, 4'h2);
      for (int k = 0; k < 3; k++) begin
         por(GROUP_PRIMARY_PLL, FPS_RC_X4 + 5'(k), OFF);
         chk(o_pll_multiplier, PLL_MUL_X4 + 2'(k), "pll mul");
      end
      por(GROUP_PRIMARY, 5'h04, OFF);
      chk(o_pll_multiplier, 2'h0, "no pll");
      $display("test pll done");
      osc_edges = 0;
      repeat (20) @(posedge i_clock);
      chk(o_clock_released, 1'b0, "held w/o osc");
      osc_run <= 1'b1;
      wait_for(0);
      chk(osc_edges >= STARTUP, 1'b1, "startup count");
      osc_run <= 1'b0;
      // let ticks still in the synchroniser drain before the restart
      repeat (8) @(posedge i_clock);
      i_sleep_wake <= 1'b1;
      @(posedge i_clock);
      i_sleep_wake <= 1'b0;
      repeat (10) @(posedge i_clock);
      chk(o_clock_released, 1'b0, "held after wake");
      osc_edges = 0;
      osc_run <= 1'b1;
      wait_for(0);
      chk(osc_edges >= STARTUP, 1'b1, "wake count");
      $display("test startup done");
      i_powerup_timer_done <= 1'b1;
      wait_for(3);
      i_watchdog_enable <= 1'b1;
      repeat (4) @(posedge i_clock);
      chk(o_slow_rc_on, 1'b1, "slow rc for watchdog");
      i_watchdog_enable <= 1'b0;
      $display("test slow rc done");
      // read-only current group bits get random filler
      for (int k = 0; k < 16; k++) begin
         t = 4'(k);
         i_software_watchdog_enable <= $random(seed);
         bus(1'b1, ADDR_CONTROL, {t[3:2], 2'($random(seed)), t[1:0], 10'h0},
             4'h2);
         chk(o_frc_trim, t, "trim out");
         bus(1'b0, ADDR_CONTROL, 16'h0, 4'h3);
         chk({rdat[15:14], rdat[11:10]}, t, "trim read");
         chk(rdat[13:12], GROUP_PRIMARY[1:0], "cur group ro");
      end
      bus(1'b1, ADDR_CONTROL, 16'h0, 4'h2);
      $display("test trim done");
      lowb(8'h02);
      repeat (4) @(posedge i_clock);
      chk(o_secondary_osc_on, 1'b1, "secondary on");
      i_sleep <= 1'b1;
      repeat (4) @(posedge i_clock);
      chk(o_secondary_osc_on, 1'b1, "secondary in sleep");
      i_sleep <= 1'b0;
      lowb(8'h00);
      bus(1'b1, ADDR_CONTROL, 16'h0002, 4'h1);
      bus(1'b0, ADDR_CONTROL, 16'h0, 4'h3);
      chk(rdat[1], 1'b0, "unkeyed write refused");
      i_pll_lock <= 1'b1;
      repeat (6) @(posedge i_clock);
      bus(1'b0, ADDR_CONTROL, 16'h0, 4'h3);
      chk(rdat[5], 1'b1, "lock set");
      i_pll_lock <= 1'b0;
      repeat (6) @(posedge i_clock);
      bus(1'b0, ADDR_CONTROL, 16'h0, 4'h3);
      chk(rdat[5], 1'b0, "lock lost");
      bus(1'b0, 4'h8, 16'h0, 4'h3);
      chk(rdat, 32'h0, "unmapped read");
      $display("test register done");
      por(GROUP_PRIMARY, 5'h04, 3'h0);
      wait_for(0);
      i_powerup_timer_done <= 1'b1;
      repeat (8) @(posedge i_clock);
      chk(o_slow_rc_on, 1'b1, "slow rc for monitor");
      trap_base = trap_cnt;
      sys_run <= 1'b0;
      wait_for(1);
      sys_run <= 1'b1;
      chk(o_active_group, GROUP_FAST_RC, "fail to rc");
      bus(1'b0, ADDR_CONTROL, 16'h0, 4'h3);
      chk({rdat[3], rdat[0]}, 2'b10, "fail flags");
      $display("test clock fail done");
      osc_run <= 1'b0;
      // system clock comes from the crystal, so it is absent too
      sys_run <= 1'b0;
      por(GROUP_PRIMARY, 5'h04, 3'h0);
      trap_base = trap_cnt;
      i_powerup_timer_done <= 1'b1;
      wait_for(1);
      sys_run <= 1'b1;
      chk(o_active_group, GROUP_FAST_RC, "slow start to rc");
      $display("test slow start done");
      lowb(8'h00);
      bus(1'b1, ADDR_CONTROL, {5'h0, GROUP_SLOW_RC, 8'h00}, 4'h2);
      lowb(8'h01);
      grp_want = GROUP_SLOW_RC;
      wait_for(2);
      chk(o_slow_rc_on, 1'b1, "slow rc selected");
      // a crystal target that never starts parks in the wait state
      bus(1'b1, ADDR_CONTROL, {5'h0, GROUP_PRIMARY, 8'h00}, 4'h2);
      lowb(8'h01);
      repeat (4) @(posedge i_clock);
      lowb(8'h00);
      bus(1'b0, ADDR_STATUS, 16'h0, 4'h3);
      chk(rdat[3:0], {GROUP_SLOW_RC, 1'b1}, "abort idle");
      chk(o_active_group, GROUP_SLOW_RC, "abort keeps group");
      por(GROUP_FAST_RC, 5'h04, OFF);
      bus(1'b1, ADDR_CONTROL, {5'h0, GROUP_SLOW_RC, 8'h00}, 4'h2);
      lowb(8'h01);
      repeat (20) @(posedge i_clock);
      chk(o_active_group, GROUP_FAST_RC, "switch disabled");
      $display("test switching done");
      report_and_stop();
   end
endmodule
`default_nettype wire
